// ### pkg/lsx_pkg.sv
package lsx_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_INSTR    = 8'h04;
	localparam logic [7:0] OFS_SRCA_LO  = 8'h08;
	localparam logic [7:0] OFS_SRCA_HI  = 8'h0C;
	localparam logic [7:0] OFS_SRCB_LO  = 8'h10;
	localparam logic [7:0] OFS_SRCB_HI  = 8'h14;
	localparam logic [7:0] OFS_RES_LO   = 8'h18;
	localparam logic [7:0] OFS_RES_HI   = 8'h1C;
	localparam logic [7:0] OFS_STATUS   = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h2C;
	localparam logic [7:0] OFS_PBOT_LO  = 8'h30;
	localparam logic [7:0] OFS_PBOT_HI  = 8'h34;
	localparam logic [7:0] OFS_PTOP_LO  = 8'h38;
	localparam logic [7:0] OFS_PTOP_HI  = 8'h3C;

	// Control register fields
	localparam int CTRL_GO_BIT   = 0;
	localparam int CTRL_M64_BIT  = 1;
	localparam int CTRL_KERN_BIT = 2;
	localparam int CTRL_BCPU_BIT = 3;
	localparam int CTRL_BMEM_BIT = 4;
	localparam int CTRL_SWAP_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// Interrupt status fields
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_EXC_BIT  = 1;

	// Opcodes and function codes
	localparam logic [5:0] OP_SPECIAL  = 6'h00;
	localparam logic [5:0] OP_DISJ_IMM = 6'h0D;
	localparam logic [5:0] OP_ST_BYTE  = 6'h28;
	localparam logic [5:0] OP_ST_UPPER = 6'h2C;
	localparam logic [5:0] OP_ST_LOWER = 6'h2D;
	localparam logic [5:0] OP_ST_DWORD = 6'h3F;
	localparam logic [5:0] FN_NOR      = 6'h27;
	localparam logic [5:0] FN_OR       = 6'h25;
	localparam logic [5:0] FN_UMUL     = 6'h19;

	// Access types sent to memory
	localparam logic [2:0] ACC_BYTE  = 3'h0;
	localparam logic [2:0] ACC_DWORD = 3'h7;

	typedef enum logic [2:0] {
		EXC_NONE    = 3'h0,
		EXC_ADDR    = 3'h1,
		EXC_RESV    = 3'h2,
		EXC_REFILL  = 3'h3,
		EXC_INVALID = 3'h4,
		EXC_MODIFY  = 3'h5,
		EXC_BUS     = 3'h6
	} lsx_exc_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_XLATE = 3'b010,
		ST_STORE = 3'b100
	} lsx_state_t;

	typedef struct packed {
		logic [63:0] vaddr;
		logic [2:0]  offset;
		logic [2:0]  acc_type;
		logic [63:0] data;
	} lsx_store_t;

endpackage : lsx_pkg

// ### src/lsx_exec.sv
// Notes on behaviour
// - Function 100111 writes inverted OR of both sources, never traps.
// - OR writes bitwise OR of both sources, never traps.
// - Immediate OR zero-extends immediate into low halfword; upper bits pass.
// - Store byte 101000 forms base plus signed offset, stores lowest byte.
// - Byte lane is address low bits XOR cpu order; data shifted, byte type.
// - Store doubleword 111111 traps address error on misaligned address.
// - Aligned store doubleword translates and stores full 64-bit register.
// - Doubleword stores need 64-bit or kernel mode, else reserved trap.
// - Stores report TLB refill, invalid, modify, bus and address errors.
// - Upper-part store writes top byte first, down to doubleword end.
// - Unaligned doubleword stores never trap for misalignment.
// - Unaligned stores XOR offset with swap flag; little memory forces zero.
// - Upper-part data is register shifted down; access type is lane.
// - Lower-part store 101101 writes low byte first, upward in doubleword.
// - Lower-part data shifted up by lane bytes; type is seven minus lane.
// - Upper-part offset follows memory order and physical address; type equals lane.
// - Unsigned multiply puts low word bottom, high word top, sign-extended in 64-bit mode, else zero-extended.
module lsx_exec #(
	parameter int PA_W = 32
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Avalon-MM slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Interrupt
	output logic                   irq,
	// Address translation
	output logic                   xl_req,
	output logic      [63:0]       xl_vaddr,
	input  wire logic              xl_ack,
	input  wire logic [PA_W-1:0]   xl_paddr,
	input  wire logic [2:0]        xl_exc,
	// Memory store
	output logic                   st_valid,
	output lsx_pkg::lsx_store_t    st_req,
	input  wire logic              st_ready,
	input  wire logic              st_berr
);
	import lsx_pkg::*;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
						 input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic logic [63:0] sext32(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction : sext32

	// Registers
	logic [5:0]  ctrl_q;
	logic        go_q;
	logic [31:0] instr_q;
	logic [63:0] srca_q;
	logic [63:0] srcb_q;
	logic [63:0] result_q;
	logic [63:0] pbot_q;
	logic [63:0] ptop_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_en_q;
	logic        ack_q;
	logic [31:0] rdata_q;
	lsx_state_t  state_q;
	lsx_exc_t    exc_q;
	logic [5:0]  kind_q;
	logic [63:0] vaddr_q;
	logic [2:0]  lane_q;
	logic [2:0]  type_q;
	logic [63:0] data_q;
	logic [2:0]  offs_q;
	lsx_store_t  store_q;

	// Mode flags
	wire m64  = ctrl_q[CTRL_M64_BIT];
	wire kern = ctrl_q[CTRL_KERN_BIT];
	wire bcpu = ctrl_q[CTRL_BCPU_BIT];
	wire bmem = ctrl_q[CTRL_BMEM_BIT];
	wire swap = ctrl_q[CTRL_SWAP_BIT];

	// Bus decode
	wire        bus_req  = avs_read | avs_write;
	wire        wr_fire  = avs_write & ack_q;
	wire [31:0] wd       = avs_writedata;
	wire [3:0]  be       = avs_byteenable;
	logic [31:0] rd_mux;
	always_comb begin
		unique case (avs_address)
			OFS_CTRL:     rd_mux = {26'h000_0000, ctrl_q};
			OFS_INSTR:    rd_mux = instr_q;
			OFS_SRCA_LO:  rd_mux = srca_q[31:0];
			OFS_SRCA_HI:  rd_mux = srca_q[63:32];
			OFS_SRCB_LO:  rd_mux = srcb_q[31:0];
			OFS_SRCB_HI:  rd_mux = srcb_q[63:32];
			OFS_RES_LO:   rd_mux = result_q[31:0];
			OFS_RES_HI:   rd_mux = result_q[63:32];
			OFS_STATUS:   rd_mux = {28'h000_0000, exc_q, ~state_q[0]};
			OFS_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat_q};
			OFS_IRQ_EN:   rd_mux = {30'h0000_0000, irq_en_q};
			OFS_PBOT_LO:  rd_mux = pbot_q[31:0];
			OFS_PBOT_HI:  rd_mux = pbot_q[63:32];
			OFS_PTOP_LO:  rd_mux = ptop_q[31:0];
			OFS_PTOP_HI:  rd_mux = ptop_q[63:32];
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	assign avs_waitrequest = bus_req & ~ack_q;
	assign avs_readdata    = rdata_q;

	// Instruction decode
	wire [5:0]  opc     = instr_q[31:26];
	wire [5:0]  fn      = instr_q[5:0];
	wire [15:0] imm     = instr_q[15:0];
	wire        is_sp   = (opc == OP_SPECIAL);
	wire        op_nor  = is_sp & (fn == FN_NOR);
	wire        op_or   = is_sp & (fn == FN_OR);
	wire        op_mul  = is_sp & (fn == FN_UMUL);
	wire        op_dimm = (opc == OP_DISJ_IMM);
	wire        op_stb  = (opc == OP_ST_BYTE);
	wire        op_std  = (opc == OP_ST_DWORD);
	wire        op_stu  = (opc == OP_ST_UPPER);
	wire        op_stl  = (opc == OP_ST_LOWER);
	wire        op_dw   = op_std | op_stu | op_stl;
	wire        op_st   = op_stb | op_dw;
	wire        op_alu  = op_nor | op_or | op_mul | op_dimm;
	wire        dw_ok   = m64 | kern;

	wire [63:0] vaddr   = srca_q + {{48{imm[15]}}, imm};
	wire [2:0]  lane    = vaddr[2:0] ^ {3{bcpu}};
	wire [5:0]  lsh     = {lane, 3'b000};
	wire [5:0]  rsh     = 6'd56 - lsh;

	// ALU results
	wire [63:0] res_nor = ~(srca_q | srcb_q);
	wire [63:0] res_or  = srca_q | srcb_q;
	wire [63:0] res_ori = {srca_q[63:16], imm | srca_q[15:0]};
	wire [63:0] prod    = {32'h0000_0000, srca_q[31:0]} * {32'h0000_0000, srcb_q[31:0]};
	wire [63:0] p_bot   = m64 ? sext32(prod[31:0]) : {32'h0000_0000, prod[31:0]};
	wire [63:0] p_top   = m64 ? sext32(prod[63:32]) : {32'h0000_0000, prod[63:32]};

	// Store data and access type
	logic [63:0] sdata;
	logic [2:0]  stype;
	always_comb begin
		sdata = srcb_q;
		stype = ACC_DWORD;
		if (op_stb) begin
			sdata = srcb_q << lsh;
			stype = ACC_BYTE;
		end else if (op_stu) begin
			sdata = srcb_q >> rsh;
			stype = lane;
		end else if (op_stl) begin
			sdata = srcb_q << lsh;
			stype = ACC_DWORD - lane;
		end
	end

	// alignment check for full doubleword only
	wire        misal   = op_std & (vaddr[2:0] != 3'h0);
	lsx_exc_t   pre_exc;
	assign pre_exc = (op_dw & ~dw_ok) ? EXC_RESV : (misal ? EXC_ADDR : EXC_NONE);

	wire        unal_q  = (kind_q == OP_ST_UPPER) | (kind_q == OP_ST_LOWER);
	wire [2:0]  poffs   = (unal_q & ~bmem) ? 3'h0 : (xl_paddr[2:0] ^ {3{swap}});

	lsx_exc_t   xl_code;
	always_comb begin
		unique case (xl_exc)
			3'h1:    xl_code = EXC_REFILL;
			3'h2:    xl_code = EXC_INVALID;
			3'h3:    xl_code = EXC_MODIFY;
			3'h6:    xl_code = EXC_BUS;
			3'h4:    xl_code = EXC_ADDR;
			default: xl_code = EXC_NONE;
		endcase
	end

	wire start     = go_q & state_q[0];
	wire xl_done   = (state_q == ST_XLATE) & xl_ack;
	wire st_done   = (state_q == ST_STORE) & st_ready;
	wire ev_done   = (start & (op_alu | ~op_st | (pre_exc != EXC_NONE)))
		       | (xl_done & (xl_code != EXC_NONE)) | st_done;
	wire ev_exc    = (start & ((pre_exc != EXC_NONE) | ~(op_st | op_alu)))
		       | (xl_done & (xl_code != EXC_NONE)) | (st_done & st_berr);

	assign xl_req   = (state_q == ST_XLATE);
	assign xl_vaddr = vaddr_q;
	// write only issued after clean translation
	assign st_valid = (state_q == ST_STORE);
	assign st_req   = store_q;
	assign irq      = |(irq_stat_q & irq_en_q);

	always_comb begin
		store_q.vaddr    = vaddr_q;
		store_q.offset   = offs_q;
		store_q.acc_type = type_q;
		store_q.data     = data_q;
	end

	// Bus slave
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= bus_req & ~ack_q;
			rdata_q <= (avs_read & ~ack_q) ? rd_mux : rdata_q;
		end
	end

	// Software registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_q   <= CTRL_RESET;
			go_q     <= 1'b0;
			instr_q  <= 32'h0000_0000;
			srca_q   <= 64'h0000_0000_0000_0000;
			srcb_q   <= 64'h0000_0000_0000_0000;
			irq_en_q <= 2'h0;
		end else begin
			go_q <= wr_fire & (avs_address == OFS_CTRL) & be[0] & wd[CTRL_GO_BIT];
			if (wr_fire) begin
				unique case (avs_address)
					OFS_CTRL:    ctrl_q <= be[0] ? {wd[5:1], 1'b0} : ctrl_q;
					OFS_INSTR:   instr_q <= be_merge(instr_q, wd, be);
					OFS_SRCA_LO: srca_q[31:0] <= be_merge(srca_q[31:0], wd, be);
					OFS_SRCA_HI: srca_q[63:32] <= be_merge(srca_q[63:32], wd, be);
					OFS_SRCB_LO: srcb_q[31:0] <= be_merge(srcb_q[31:0], wd, be);
					OFS_SRCB_HI: srcb_q[63:32] <= be_merge(srcb_q[63:32], wd, be);
					OFS_IRQ_EN:  irq_en_q <= be[0] ? wd[1:0] : irq_en_q;
					default: ;
				endcase
			end
		end
	end

	// Sticky events, set wins over clear
	wire [1:0] clr = (wr_fire & (avs_address == OFS_IRQ_CLR) & be[0]) ? wd[1:0] : 2'h0;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_stat_q <= 2'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr) | {ev_exc, ev_done};
		end
	end

	// Results
	always_ff @(posedge clk) begin
		if (!resetn) begin
			result_q <= 64'h0000_0000_0000_0000;
			pbot_q   <= 64'h0000_0000_0000_0000;
			ptop_q   <= 64'h0000_0000_0000_0000;
		end else if (start) begin
			if (op_nor) begin
				result_q <= res_nor;
			end
			if (op_or) begin
				result_q <= res_or;
			end
			if (op_dimm) begin
				result_q <= res_ori;
			end
			if (op_mul) begin
				pbot_q <= p_bot;
				ptop_q <= p_top;
			end
		end
	end

	// Store sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			exc_q   <= EXC_NONE;
			kind_q  <= 6'h00;
			vaddr_q <= 64'h0000_0000_0000_0000;
			type_q  <= 3'h0;
			data_q  <= 64'h0000_0000_0000_0000;
			offs_q  <= 3'h0;
			lane_q  <= 3'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start) begin
						exc_q <= (op_st | op_alu) ? pre_exc : EXC_RESV;
						if (op_st & (pre_exc == EXC_NONE)) begin
							state_q <= ST_XLATE;
							kind_q  <= opc;
							vaddr_q <= vaddr;
							lane_q  <= lane;
							data_q  <= sdata;
							type_q  <= stype;
						end
					end
				end
				ST_XLATE: begin
					if (xl_ack) begin
						if (xl_code != EXC_NONE) begin
							exc_q   <= xl_code;
							state_q <= ST_IDLE;
						end else begin
							offs_q  <= poffs;
							state_q <= ST_STORE;
						end
					end
				end
				ST_STORE: begin
					if (st_ready) begin
						exc_q   <= st_berr ? EXC_BUS : EXC_NONE;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_xl_ok;
		(state_q == ST_XLATE) && xl_ack && (xl_code == EXC_NONE);
	endsequence
	sequence s_xl_bad;
		(state_q == ST_XLATE) && xl_ack && (xl_code != EXC_NONE);
	endsequence

	a_nor_result: assert property (start && op_nor |=>
		result_q == ~($past(srca_q) | $past(srcb_q))) else $error("nor result wrong");
	a_or_result: assert property (start && op_or |=>
		result_q == ($past(srca_q) | $past(srcb_q)) && exc_q == EXC_NONE)
		else $error("or result wrong");
	a_ori_upper: assert property (start && op_dimm |=>
		result_q[63:16] == $past(srca_q[63:16])) else $error("immediate or upper wrong");
	a_byte_lane_data: assert property (start && op_stb && pre_exc == EXC_NONE |=>
		data_q == ($past(srcb_q) << {lane_q, 3'b000}) && type_q == ACC_BYTE)
		else $error("byte lane data wrong");
	a_dw_align_trap: assert property (start && op_std && dw_ok && vaddr[2:0] != 3'h0 |=>
		exc_q == EXC_ADDR && state_q == ST_IDLE) else $error("misaligned store accepted");
	a_dw_mode_trap: assert property (start && op_dw && !dw_ok |=>
		exc_q == EXC_RESV && !st_valid) else $error("mode trap missing");
	a_store_issue: assert property (s_xl_ok |=> st_valid && st_req.vaddr == xl_vaddr)
		else $error("store not issued after translation");
	a_no_trap_write: assert property (s_xl_bad |=> !st_valid [*2])
		else $error("store issued after trap");
	a_lower_type: assert property (start && op_stl && dw_ok |=>
		type_q == 3'h7 - lane_q) else $error("lower part type wrong");
	a_upper_type: assert property (start && op_stu && dw_ok |=> type_q == lane_q)
		else $error("upper part type wrong");
	a_unal_offset: assert property (st_valid && unal_q && !bmem |-> st_req.offset == 3'h0)
		else $error("offset not forced to zero");
	a_mul_split: assert property (start && op_mul && m64 |=>
		pbot_q[63:31] == {33{pbot_q[31]}}) else $error("product not sign extended");

endmodule : lsx_exec

// ### sim/lsx_mem_model.sv
module lsx_mem_model #(
	parameter int PA_W = 32
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// Translation
	input  wire logic                xl_req,
	input  wire logic [63:0]         xl_vaddr,
	output logic                     xl_ack,
	output logic      [PA_W-1:0]     xl_paddr,
	output logic      [2:0]          xl_exc,
	// Store
	input  wire logic                st_valid,
	input  wire lsx_pkg::lsx_store_t st_req,
	output logic                     st_ready,
	output logic                     st_berr,
	// Scenario control
	input  wire logic [3:0]          dly,
	input  wire logic [2:0]          exc_sel,
	input  wire logic                berr_sel,
	output int                       n_st,
	output lsx_pkg::lsx_store_t      last_st
);
	import lsx_pkg::*;
	logic [3:0]      xl_cnt_q;
	logic [3:0]      st_cnt_q;
	logic [PA_W-1:0] pa_w;
	// Answer lines carry junk outside their strobe
	assign pa_w     = {~xl_vaddr[PA_W-1], xl_vaddr[PA_W-2:0]};
	assign xl_paddr = xl_ack ? pa_w : ~pa_w;
	assign xl_exc   = xl_ack ? exc_sel : ~exc_sel;
	assign st_berr  = st_ready ? berr_sel : ~berr_sel;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			xl_ack   <= 1'b0;
			st_ready <= 1'b0;
			xl_cnt_q <= 4'h0;
			st_cnt_q <= 4'h0;
			n_st     <= 0;
		end else begin
			xl_cnt_q <= (xl_req && !xl_ack) ? xl_cnt_q + 4'h1 : 4'h0;
			xl_ack   <= xl_req && !xl_ack && xl_cnt_q == dly;
			st_cnt_q <= (st_valid && !st_ready) ? st_cnt_q + 4'h1 : 4'h0;
			st_ready <= st_valid && !st_ready && st_cnt_q == dly;
			if (st_valid && st_ready) begin
				n_st    <= n_st + 1;
				last_st <= st_req;
			end
		end
	end
endmodule : lsx_mem_model

// ### sim/lsx_exec_test.sv
module lsx_exec_test;
	timeunit 1ns;
	timeprecision 1ns;
	import lsx_pkg::*;
	localparam logic [5:0]  M64 = 6'h02;
	localparam logic [5:0]  KERN = 6'h04;
	localparam logic [5:0]  BCPU = 6'h08;
	localparam logic [5:0]  BMEM = 6'h10;
	localparam logic [5:0]  SWAP = 6'h20;
	localparam logic [63:0] A = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] B = 64'h1122_3344_5566_7788;
	logic        clk, resetn, avs_read, avs_write, avs_waitrequest, irq, irq_on;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_q, xl_paddr;
	logic [3:0]  avs_byteenable, dly;
	logic        xl_req, xl_ack, st_valid, st_ready, st_berr, berr_sel;
	logic [63:0] xl_vaddr, v64, msk;
	logic [2:0]  xl_exc, exc_sel, lane;
	logic [5:0]  ctl;
	lsx_store_t  st_req, last_st;
	int          n_st, n_errors, total_checks, cyc, n0;
	logic [2:0]  exc_map [4] = '{EXC_REFILL, EXC_INVALID, EXC_MODIFY, EXC_ADDR};

	lsx_exec #(.PA_W(32)) dut_u (.clk, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .xl_req,
		.xl_vaddr, .xl_ack, .xl_paddr, .xl_exc, .st_valid, .st_req, .st_ready, .st_berr);
	lsx_mem_model #(.PA_W(32)) mem_u (.clk, .resetn, .xl_req, .xl_vaddr, .xl_ack, .xl_paddr,
		.xl_exc, .st_valid, .st_req, .st_ready, .st_berr, .dly, .exc_sel, .berr_sel, .n_st,
		.last_st);

	always #20 clk = ~clk;

	task report_and_stop;
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			report_and_stop;
		end
	end

	task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			n_errors++;
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task rd64(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
		v64[31:0] = rd_q;
		bus(1'b0, a + 8'h04, 32'h0);
		v64[63:32] = rd_q;
	endtask : rd64

	function automatic logic [31:0] enc(input logic [5:0] op, input logic [15:0] lo);
		return {op, 5'h01, 5'h02, lo};
	endfunction : enc

	task run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
		input logic [5:0] c, input logic [2:0] ex, input logic [1:0] st);
		int n;
		n0 = n_st;
		bus(1'b1, OFS_INSTR, ins);
		bus(1'b1, OFS_SRCA_LO, a[31:0]);
		bus(1'b1, OFS_SRCA_HI, a[63:32]);
		bus(1'b1, OFS_SRCB_LO, b[31:0]);
		bus(1'b1, OFS_SRCB_HI, b[63:32]);
		bus(1'b1, OFS_CTRL, {26'h0, c | 6'h01});
		n = 0;
		do begin
			bus(1'b0, OFS_IRQ_STAT, 32'h0);
			n++;
		end while (rd_q[IRQ_DONE_BIT] !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		check("exc flag", rd_q[IRQ_EXC_BIT], ex != 3'h0);
		check("irq", irq, irq_on);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status", rd_q, {28'h000_0000, ex, 1'b0});
		check("stores", n_st - n0, st);
		bus(1'b1, OFS_IRQ_CLR, 32'h3);
		bus(1'b0, OFS_IRQ_STAT, 32'h0);
		check("irq stat clr", rd_q, 32'h0);
		check("irq clr", irq, 1'b0);
		rd64(OFS_RES_LO);
	endtask : run

	task cst(input logic [63:0] va, input logic [2:0] off, input logic [2:0] typ,
		input logic [63:0] d);
		check("st vaddr", last_st.vaddr, va);
		check("st offset", last_st.offset, off);
		check("st type", last_st.acc_type, typ);
		check("st data", last_st.data, d);
	endtask : cst

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		dly = 4'h0;
		exc_sel = 3'h0;
		berr_sel = 1'b0;
		irq_on = 1'b0;
		cyc = 0;
		n_errors = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		// Reset value and unmapped place
		bus(1'b0, OFS_CTRL, 32'h0);
		check("ctrl", rd_q, 32'h0);
		check("irq rst", irq, 1'b0);
		check("st_valid rst", st_valid, 1'b0);
		bus(1'b1, 8'h40, 32'hDEAD_BEEF);
		bus(1'b0, 8'h40, 32'h0);
		check("unmapped", rd_q, 32'h0);
		// Logic operations, both modes, irq masked
		for (int m = 0; m < 2; m++) begin
			msk = m ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
			ctl = m ? M64 : 6'h00;
			run(enc(OP_SPECIAL, {5'h03, 5'h00, FN_NOR}), A, B, ctl, 3'h0, 2'h0);
			check("nor", v64 & msk, ~(A | B) & msk);
			run(enc(OP_SPECIAL, {5'h03, 5'h00, FN_OR}), A, B, ctl, 3'h0, 2'h0);
			check("or", v64 & msk, (A | B) & msk);
			run(enc(OP_DISJ_IMM, 16'h8421), A, B, ctl, 3'h0, 2'h0);
			check("ori", v64 & msk, (A | 64'h8421) & msk);
		end
		bus(1'b1, OFS_IRQ_EN, 32'h3);
		bus(1'b0, OFS_IRQ_EN, 32'h0);
		check("irq en", rd_q, 32'h3);
		irq_on = 1'b1;
		run(enc(OP_SPECIAL, {10'h000, FN_UMUL}), 64'hFFFF_FFFF, 64'hFFFF_FFFF, M64, 3'h0, 2'h0);
		rd64(OFS_PBOT_LO);
		check("pbot", v64, 64'h1);
		rd64(OFS_PTOP_LO);
		check("ptop", v64, 64'hFFFF_FFFF_FFFF_FFFE);
		run(enc(OP_SPECIAL, {10'h000, FN_UMUL}), 64'hFFFF_FFFF, 64'h2, 6'h00, 3'h0, 2'h0);
		rd64(OFS_PBOT_LO);
		check("pbot 32", v64, 64'hFFFF_FFFE);
		rd64(OFS_PTOP_LO);
		check("ptop 32", v64, 64'h1);
		// Byte store, both cpu byte orders
		for (int c = 0; c < 2; c++) begin
			lane = 3'h3 ^ {3{c[0]}};
			run(enc(OP_ST_BYTE, 16'hFFFB), 64'h1_0000_1000, B, c ? BCPU : 6'h00, 3'h0, 2'h1);
			cst(64'h1_0000_0FFB, 3'h3, ACC_BYTE, B << (8 * lane));
		end
		// Doubleword store by alignment and mode
		run(enc(OP_ST_DWORD, 16'h0010), 64'h2000, B, M64, 3'h0, 2'h1);
		cst(64'h2010, 3'h0, ACC_DWORD, B);
		run(enc(OP_ST_DWORD, 16'h0012), 64'h2000, B, M64, EXC_ADDR, 2'h0);
		run(enc(OP_ST_DWORD, 16'h0010), 64'h2000, B, 6'h00, EXC_RESV, 2'h0);
		run(enc(OP_ST_DWORD, 16'h0010), 64'h2000, B, KERN, 3'h0, 2'h1);
		run(enc(OP_ST_UPPER, 16'h0000), 64'h3000, B, 6'h00, EXC_RESV, 2'h0);
		// Undecoded instruction traps as reserved
		run(enc(6'h01, 16'h0000), A, B, M64, EXC_RESV, 2'h0);
		// Upper-part store, every address offset but even lanes only, little memory
		for (int k = 0; k < 8; k++) begin
			lane = k[2:0] ^ {3{k[0]}};
			ctl = M64 | (k[0] ? BCPU : 6'h00);
			run(enc(OP_ST_UPPER, 16'(k)), 64'h3000, B, ctl, 3'h0, 2'h1);
			cst(64'h3000 + k, 3'h0, lane, B >> (8 * (7 - lane)));
		end
		// Lower-part store, big memory, swap and cpu order varied
		for (int k = 0; k < 8; k++) begin
			lane = k[2:0] ^ {3{k[1]}};
			ctl = M64 | BMEM | (k[0] ? SWAP : 6'h00) | (k[1] ? BCPU : 6'h00);
			run(enc(OP_ST_LOWER, 16'(k)), 64'h3008, B, ctl, 3'h0, 2'h1);
			cst(64'h3008 + k, k[2:0] ^ {3{k[0]}}, 3'h7 - lane, B << (8 * lane));
		end
		// Translation faults, slow answers, then a store bus error
		for (int e = 0; e < 4; e++) begin
			exc_sel <= 3'(e + 1);
			dly <= 4'(e * 3);
			run(enc(OP_ST_DWORD, 16'h0010), 64'h2000, B, M64, exc_map[e], 2'h0);
		end
		exc_sel <= 3'h0;
		berr_sel <= 1'b1;
		run(enc(OP_ST_DWORD, 16'h0010), 64'h2000, B, M64, EXC_BUS, 2'h1);
		report_and_stop;
	end
endmodule : lsx_exec_test
